// ==== core/ascic_cfg.svh ====
`ifndef ASCIC_CFG_SVH
`define ASCIC_CFG_SVH

// register port widths
`define ASCIC_AW 4
`define ASCIC_DW 16

// register word indices
`define ASCIC_ADDR_CTRL 4'h0
`define ASCIC_ADDR_RES 4'h1
`define ASCIC_ADDR_STAT 4'h2
`define ASCIC_ADDR_RDY 4'h3
`define ASCIC_ADDR_EARLY 4'h4

// converter_control_two_low field positions
`define ASCIC_BIT_REF_RDY_EN 15
`define ASCIC_BIT_REF_ERR_EN 14
`define ASCIC_BIT_EARLY_SEL 12
`define ASCIC_SEL_HI 10
`define ASCIC_SEL_LO 8
`define ASCIC_BIT_RSVD_HI 13
`define ASCIC_BIT_UNIMP 7

// resolution register field
`define ASCIC_RES_HI 6
`define ASCIC_RES_LO 5

// status register field positions
`define ASCIC_BIT_STAT_RDY 15
`define ASCIC_BIT_STAT_ERR 14

// reset values
`define ASCIC_SEL_RST 3'h0
`define ASCIC_RES_RST 2'h3

// timer counter width and conversion lengths in core clock periods
`define ASCIC_CNT_W 4
`define ASCIC_LEAD_OFS 4'h1
`define ASCIC_LEN_6 4'h6
`define ASCIC_LEN_8 4'h8
`define ASCIC_LEN_10 4'ha
`define ASCIC_LEN_12 4'hc
`define ASCIC_REM_LAST 4'h1

`endif

// ==== core/ascic_pkg.sv ====
package ascic_pkg;

    typedef enum logic [1:0] {
        RES_6 = 2'b00,
        RES_8 = 2'b01,
        RES_10 = 2'b10,
        RES_12 = 2'b11
    } ascic_res_t;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_CONV = 1'b1
    } ascic_tmr_state_t;

endpackage

// ==== core/ascic_tmr_if.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ascic_cfg.svh"

interface ascic_tmr_if;
    logic start;
    logic tick;
    logic [`ASCIC_CNT_W-1:0] lead;
    logic [`ASCIC_CNT_W-1:0] len;
    logic idle;
    logic early_pulse;
    logic ready_pulse;

    modport ctrl (
        output start, tick, lead, len,
        input idle, early_pulse, ready_pulse
    );
    modport tmr (
        input start, tick, lead, len,
        output idle, early_pulse, ready_pulse
    );
endinterface

`default_nettype wire

// ==== core/ascic_early_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ascic_cfg.svh"

module ascic_early_timer (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    ascic_tmr_if.tmr t
);
    ascic_pkg::ascic_tmr_state_t state;
    logic [`ASCIC_CNT_W-1:0] rem;
    logic [`ASCIC_CNT_W-1:0] lead_q;
    logic [`ASCIC_CNT_W-1:0] rem_dec;

    assign rem_dec = rem - `ASCIC_LEAD_OFS;
    assign t.idle = (state == ascic_pkg::ST_IDLE);

    // conversion countdown; a start while busy is ignored
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state <= ascic_pkg::ST_IDLE;
            rem <= '0;
            lead_q <= '0;
        end else begin
            case (state)
                ascic_pkg::ST_IDLE: begin
                    if (t.start) begin
                        state <= ascic_pkg::ST_CONV;
                        rem <= t.len;
                        lead_q <= t.lead;
                    end
                end
                ascic_pkg::ST_CONV: begin
                    if (t.tick) begin
                        rem <= rem_dec;
                        if (rem == `ASCIC_REM_LAST) begin
                            state <= ascic_pkg::ST_IDLE;
                        end
                    end
                end
                default: state <= ascic_pkg::ST_IDLE;
            endcase
        end
    end

    // early pulse when lead periods remain; lead at or past length fires at start
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            t.early_pulse <= 1'b0;
            t.ready_pulse <= 1'b0;
        end else begin
            t.early_pulse <= (t.idle && t.start && (t.lead >= t.len)) ||
                (!t.idle && t.tick && (rem_dec == lead_q));
            t.ready_pulse <= !t.idle && t.tick &&
                (rem == `ASCIC_REM_LAST);
        end
    end

    AST_EARLY_TIME: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        (t.early_pulse && $past(state) == ascic_pkg::ST_CONV)
            |-> (rem == lead_q))
        else $error("early pulse not at lead periods before ready");

    AST_READY_END: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        t.ready_pulse |-> (rem == '0 && t.idle && !$past(t.idle)))
        else $error("ready pulse without finished conversion");

    AST_LEN_LOAD: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        (t.idle && t.start) |=> (rem == $past(t.len) && !t.idle))
        else $error("conversion length not loaded at start");

    COV_EARLY_MID: cover property (
        @(posedge sys_clk_i) disable iff (rst_i)
        t.early_pulse && $past(state) == ascic_pkg::ST_CONV);
endmodule

`default_nettype wire

// ==== core/ascic_top.sv ====
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "ascic_cfg.svh"
// Functional notes
// - ready enable set: common irq pulses when band gap becomes ready
// - error enable set: common irq pulses on reference error
// - select high: channel irq on early flag; low: on result-ready flag
// - time codes 110..001 give early flag 7..2 core periods before data
// - resolution code 11/10/01/00 selects 12/10/8/6-bit conversion
// - reference error flag sets when band gap drops while converter on

module ascic_top #(
    parameter int NUM_CH = 8
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [`ASCIC_AW-1:0] reg_addr_i,
    input wire logic [`ASCIC_DW-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [`ASCIC_DW-1:0] reg_rdata_o,
    input wire logic bandgap_ready_i,
    input wire logic converter_on_i,
    input wire logic conv_start_i,
    input wire logic [$clog2(NUM_CH)-1:0] conv_ch_i,
    input wire logic tad_tick_i,
    output logic common_irq_o,
    output logic [NUM_CH-1:0] chan_irq_o
);
    localparam int CW = $clog2(NUM_CH);

    // ready and early channel flags each pack into one 16-bit register word
    generate
        if (NUM_CH < 2 || NUM_CH > `ASCIC_DW) begin : g_bad_ch
            $error("NUM_CH must lie between 2 and 16");
        end
    endgenerate

    logic ref_rdy_en;
    logic ref_err_en;
    logic early_sel;
    logic [2:0] time_sel;
    ascic_pkg::ascic_res_t res;
    logic bg_meta;
    logic bg_sync;
    logic bg_prev;
    logic bg_rise;
    logic ref_err_set;
    logic ref_err_flag;
    logic [CW-1:0] cur_ch;
    logic [NUM_CH-1:0] rdy_flag;
    logic [NUM_CH-1:0] early_flag;
    logic wr_ctrl;
    logic wr_res;
    logic wr_rdy;
    logic wr_early;
    logic start_ok;

    ascic_tmr_if tmr ();

    ascic_early_timer u_timer (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .t(tmr)
    );

    // register write decode
    assign wr_ctrl = reg_wr_i && (reg_addr_i == `ASCIC_ADDR_CTRL);
    assign wr_res = reg_wr_i && (reg_addr_i == `ASCIC_ADDR_RES);
    assign wr_rdy = reg_wr_i && (reg_addr_i == `ASCIC_ADDR_RDY);
    assign wr_early = reg_wr_i && (reg_addr_i == `ASCIC_ADDR_EARLY);

    // control fields; reserved bits are not stored at all
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ref_rdy_en <= 1'b0;
            ref_err_en <= 1'b0;
            early_sel <= 1'b0;
            time_sel <= `ASCIC_SEL_RST;
        end else if (wr_ctrl) begin
            ref_rdy_en <= reg_wdata_i[`ASCIC_BIT_REF_RDY_EN];
            ref_err_en <= reg_wdata_i[`ASCIC_BIT_REF_ERR_EN];
            early_sel <= reg_wdata_i[`ASCIC_BIT_EARLY_SEL];
            time_sel <= reg_wdata_i[`ASCIC_SEL_HI:`ASCIC_SEL_LO];
        end
    end

    // shared core resolution, resets to 12-bit
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            res <= ascic_pkg::ascic_res_t'(`ASCIC_RES_RST);
        end else if (wr_res) begin
            res <= ascic_pkg::ascic_res_t'(
                reg_wdata_i[`ASCIC_RES_HI:`ASCIC_RES_LO]);
        end
    end

    // band gap pin is analog-side; two flops before any use
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            bg_meta <= 1'b0;
            bg_sync <= 1'b0;
            bg_prev <= 1'b0;
        end else begin
            bg_meta <= bandgap_ready_i;
            bg_sync <= bg_meta;
            bg_prev <= bg_sync;
        end
    end

    assign bg_rise = bg_sync && !bg_prev;
    assign ref_err_set = converter_on_i && bg_prev && !bg_sync;

    // error flag is cleared by hardware once the converter is off
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ref_err_flag <= 1'b0;
        end else if (ref_err_set) begin
            ref_err_flag <= 1'b1;
        end else if (!converter_on_i) begin
            ref_err_flag <= 1'b0;
        end
    end

    // common interrupt: one pulse per enabled event
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            common_irq_o <= 1'b0;
        end else begin
            common_irq_o <= (bg_rise && ref_rdy_en) ||
                (ref_err_set && ref_err_en);
        end
    end

    // timer hookup; lead is code plus one period
    assign start_ok = conv_start_i && tmr.idle;
    assign tmr.start = conv_start_i;
    assign tmr.tick = tad_tick_i;
    assign tmr.lead =
        {1'b0, time_sel} + `ASCIC_LEAD_OFS;

    // conversion length per resolution; bad codes clamp, never hang
    always_comb begin
        case (res)
            ascic_pkg::RES_6: tmr.len = `ASCIC_LEN_6;
            ascic_pkg::RES_8: tmr.len = `ASCIC_LEN_8;
            ascic_pkg::RES_10: tmr.len = `ASCIC_LEN_10;
            ascic_pkg::RES_12: tmr.len = `ASCIC_LEN_12;
            default: tmr.len = `ASCIC_LEN_12;
        endcase
    end

    // channel of the running conversion
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            cur_ch <= '0;
        end else if (start_ok) begin
            cur_ch <= conv_ch_i;
        end
    end

    // per-channel sticky flags and interrupt pulses; set beats clear
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
            logic hit;
            assign hit = (cur_ch == CW'(gi));
            always_ff @(posedge sys_clk_i) begin
                if (rst_i) begin
                    rdy_flag[gi] <= 1'b0;
                    early_flag[gi] <= 1'b0;
                    chan_irq_o[gi] <= 1'b0;
                end else begin
                    if (hit && tmr.ready_pulse) begin
                        rdy_flag[gi] <= 1'b1;
                    end else if (wr_rdy && reg_wdata_i[gi]) begin
                        rdy_flag[gi] <= 1'b0;
                    end
                    if (hit && tmr.early_pulse) begin
                        early_flag[gi] <= 1'b1;
                    end else if (wr_early && reg_wdata_i[gi]) begin
                        early_flag[gi] <= 1'b0;
                    end
                    chan_irq_o[gi] <= hit && (early_sel ?
                        tmr.early_pulse : tmr.ready_pulse);
                end
            end
        end
    endgenerate

    // read data stands only in the cycle after the strobe
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || !reg_rd_i) begin
            reg_rdata_o <= '0;
        end else begin
            reg_rdata_o <= '0; // unmapped and reserved bits read zero
            case (reg_addr_i)
                `ASCIC_ADDR_CTRL: begin
                    reg_rdata_o[`ASCIC_BIT_REF_RDY_EN] <= ref_rdy_en;
                    reg_rdata_o[`ASCIC_BIT_REF_ERR_EN] <= ref_err_en;
                    reg_rdata_o[`ASCIC_BIT_EARLY_SEL] <= early_sel;
                    reg_rdata_o[`ASCIC_SEL_HI:`ASCIC_SEL_LO] <= time_sel;
                end
                `ASCIC_ADDR_RES: begin
                    reg_rdata_o[`ASCIC_RES_HI:`ASCIC_RES_LO] <= res;
                end
                `ASCIC_ADDR_STAT: begin
                    reg_rdata_o[`ASCIC_BIT_STAT_RDY] <= bg_sync;
                    reg_rdata_o[`ASCIC_BIT_STAT_ERR] <= ref_err_flag;
                end
                `ASCIC_ADDR_RDY: reg_rdata_o <= `ASCIC_DW'(rdy_flag);
                `ASCIC_ADDR_EARLY: reg_rdata_o <= `ASCIC_DW'(early_flag);
                default: reg_rdata_o <= '0;
            endcase
        end
    end

    AST_REF_READY_IRQ: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        (bg_rise && ref_rdy_en) |=> common_irq_o)
        else $error("band gap ready did not raise common irq");

    AST_IRQ_QUIET: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        (!(bg_rise && ref_rdy_en) && !(ref_err_set && ref_err_en))
            |=> !common_irq_o)
        else $error("common irq without an enabled event");

    AST_REF_ERR_IRQ: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        (ref_err_set && ref_err_en) |=> common_irq_o)
        else $error("reference error did not raise common irq");

    AST_REF_ERR_FLAG: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        (converter_on_i && bg_prev && !bg_sync) |=> ref_err_flag)
        else $error("band gap loss while on did not set error flag");

    AST_EARLY_SEL: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        (tmr.early_pulse && early_sel)
            |=> (chan_irq_o == (NUM_CH'(1) << $past(cur_ch))))
        else $error("early select did not route early pulse");

    AST_READY_SEL: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        (!early_sel && !tmr.ready_pulse) |=> (chan_irq_o == '0))
        else $error("channel irq without ready event");

    AST_BIT7_ZERO: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        (reg_rd_i && reg_addr_i == `ASCIC_ADDR_CTRL)
            |=> (reg_rdata_o[`ASCIC_BIT_UNIMP] == 1'b0 &&
                reg_rdata_o[`ASCIC_BIT_RSVD_HI] == 1'b0))
        else $error("unimplemented control bit read nonzero");

    COV_EARLY_IRQ: cover property (
        @(posedge sys_clk_i) disable iff (rst_i)
        early_sel && tmr.early_pulse ##1 |chan_irq_o);

    COV_READY_IRQ: cover property (
        @(posedge sys_clk_i) disable iff (rst_i)
        !early_sel && tmr.ready_pulse ##1 |chan_irq_o);

    COV_ERR_IRQ: cover property (
        @(posedge sys_clk_i) disable iff (rst_i)
        ref_err_set && ref_err_en ##1 common_irq_o);
endmodule

`default_nettype wire

// ==== dv/ascic_far_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module ascic_far_model (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic bg_up_i,
    output logic bandgap_ready_o,
    output logic tad_tick_o
);
    logic [1:0] div;

    // core period of four system clocks, free running like a real divider
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            div <= 2'h0;
        end else begin
            div <= div + 2'h1;
        end
    end

    assign tad_tick_o = (div == 2'h3);

    // analog reference settles one cycle after the request
    always_ff @(posedge sys_clk_i) begin
        bandgap_ready_o <= bg_up_i;
    end
endmodule

`default_nettype wire

// ==== dv/tb_adc_shared_core_interrupt_control.sv ====
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
    $display("wrong value at %0t: got %h want %h", $time, a, b); end end

module tb_adc_shared_core_interrupt_control;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic bg_up = 1'b0;
    logic bandgap_ready;
    logic converter_on = 1'b0;
    logic conv_start = 1'b0;
    logic [2:0] conv_ch = 3'h0;
    logic tad_tick;
    logic common_irq;
    logic [7:0] chan_irq;
    int err_count = 0;
    int compares = 0;

    ascic_top #(.NUM_CH(8)) u_dut (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata),
        .reg_wr_i(reg_wr),
        .reg_rd_i(reg_rd),
        .reg_rdata_o(reg_rdata),
        .bandgap_ready_i(bandgap_ready),
        .converter_on_i(converter_on),
        .conv_start_i(conv_start),
        .conv_ch_i(conv_ch),
        .tad_tick_i(tad_tick),
        .common_irq_o(common_irq),
        .chan_irq_o(chan_irq)
    );

    ascic_far_model u_far (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .bg_up_i(bg_up),
        .bandgap_ready_o(bandgap_ready),
        .tad_tick_o(tad_tick)
    );

    // 200 MHz system clock
    initial begin
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end

    task automatic wrap_up;
        $display("counts: %0d compares, %0d wrong", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // tasks start and end just after a rising edge; the strobe drops
    // one edge before the next task may raise it again
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr <= 1'b0;
        @(posedge sys_clk_i);
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd <= 1'b0;
        @(negedge sys_clk_i);
        `CHK(reg_rdata, exp)
        @(posedge sys_clk_i);
    endtask

    // start on a known tick phase, then count core ticks up to the irq
    task automatic conv(input logic [2:0] ch, input int len, input int exp_n);
        int n;
        int hits;
        int at;
        n = 0;
        hits = 0;
        at = -1;
        @(negedge sys_clk_i);
        while (tad_tick !== 1'b1) @(negedge sys_clk_i);
        @(posedge sys_clk_i);
        conv_start <= 1'b1;
        conv_ch <= ch;
        @(posedge sys_clk_i);
        conv_start <= 1'b0;
        repeat (len * 4 + 8) begin
            @(negedge sys_clk_i);
            if (tad_tick === 1'b1) n++;
            if (chan_irq !== 8'h00) begin
                hits++;
                at = n;
                `CHK(chan_irq, 8'h01 << ch)
            end
        end
        `CHK(hits, 1)
        `CHK(at, exp_n)
        @(posedge sys_clk_i);
    endtask

    // common irq pulses seen in a short window after an analog change
    task automatic expect_common(input int exp);
        int cnt;
        cnt = 0;
        repeat (10) begin
            @(negedge sys_clk_i);
            if (common_irq === 1'b1) cnt++;
        end
        `CHK(cnt, exp)
        @(posedge sys_clk_i);
    endtask

    task automatic test_regs;
        rd(4'h0, 16'h0000);
        rd(4'h1, 16'h0060);
        wr(4'h0, 16'hd780); // reserved 13 and 11 left clear
        rd(4'h0, 16'hd700);
        wr(4'hf, 16'hffff);
        rd(4'hf, 16'h0000);
        $display("test regs done");
    endtask

    task automatic test_early;
        // 12-bit: every code valid, lead is code plus one
        wr(4'h1, 16'h0060);
        for (int c = 0; c < 8; c++) begin
            wr(4'h0, 16'h1000 | 16'(c << 8));
            conv(3'(c), 12, 12 - (c + 1));
        end
        wr(4'h1, 16'h0000);
        wr(4'h0, 16'h1300); // 6-bit keeps code at most 011
        conv(3'h5, 6, 2);
        // every channel saw both pulses; flags stick until written one
        rd(4'h3, 16'h00ff);
        rd(4'h4, 16'h00ff);
        wr(4'h3, 16'h00ff);
        wr(4'h4, 16'h00ff);
        rd(4'h3, 16'h0000);
        rd(4'h4, 16'h0000);
        $display("test early done");
    endtask

    task automatic test_ready;
        for (int r = 0; r < 4; r++) begin
            wr(4'h1, 16'(r << 5));
            wr(4'h0, 16'h0300); // code valid at every resolution
            conv(3'(r + 2), 6 + 2 * r, 6 + 2 * r);
        end
        // channels 2..5 ran; lead 4 is below every length
        rd(4'h3, 16'h003c);
        rd(4'h4, 16'h003c);
        $display("test ready done");
    endtask

    task automatic test_common;
        wr(4'h0, 16'h8000);
        bg_up <= 1'b1;
        expect_common(1);
        rd(4'h2, 16'h8000);
        bg_up <= 1'b0;
        expect_common(0);
        wr(4'h0, 16'h0000);
        bg_up <= 1'b1;
        expect_common(0);
        converter_on <= 1'b1;
        wr(4'h0, 16'h4000);
        bg_up <= 1'b0;
        expect_common(1);
        rd(4'h2, 16'h4000);
        converter_on <= 1'b0;
        expect_common(0);
        rd(4'h2, 16'h0000);
        wr(4'h0, 16'h0000);
        bg_up <= 1'b1;
        converter_on <= 1'b1;
        expect_common(0);
        bg_up <= 1'b0;
        expect_common(0);
        $display("test common done");
    endtask

    // cut a hang short well past the expected run of under a thousand cycles
    initial begin
        #100000;
        err_count++;
        wrap_up();
    end

    initial begin
        repeat (4) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        @(posedge sys_clk_i);
        test_regs();
        test_early();
        test_ready();
        test_common();
        wrap_up();
    end
endmodule

`default_nettype wire
